/* File: stpq_pkg.sv */
package stpq_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 100;
    // longest through-current guard of the driver: polarity change, sink on
    localparam int unsigned STEP_GAP_NS    = 10000;
    localparam int unsigned STEP_GAP_CYC   =
        (STEP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned ADDR_W         = 8;
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_STEP       = 8'h04;
    localparam logic [7:0]  OFS_PERIOD     = 8'h08;
    localparam logic [7:0]  OFS_STATUS     = 8'h0C;

    localparam int unsigned CTRL_DRIVE_BIT   = 0;
    localparam int unsigned CTRL_QUARTER_BIT = 1;
    localparam int unsigned CTRL_REVERSE_BIT = 2;
    localparam int unsigned CTRL_W           = 3;
    localparam logic [2:0]  CTRL_RST         = 3'h0;

    localparam int unsigned STAT_POS_LSB   = 0;
    localparam int unsigned STAT_BUSY_BIT  = 4;
    localparam int unsigned STAT_PINS_LSB  = 8;

    localparam int unsigned CNT_W          = 16;
    localparam logic [15:0] PERIOD_RST     = 16'(STEP_GAP_CYC);
    localparam logic [15:0] PERIOD_MIN     = 16'(STEP_GAP_CYC);

    // {level_sel_high, level_sel_low}
    localparam logic [1:0]  LVL_FULL       = 2'h0;
    localparam logic [1:0]  LVL_TWO_THIRD  = 2'h1;
    localparam logic [1:0]  LVL_ONE_THIRD  = 2'h2;
    localparam logic [1:0]  LVL_ZERO       = 2'h3;

    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic [1:0]  HRESP_OKAY     = 2'h0;

    typedef struct packed {
        logic winding_a_polarity;
        logic winding_a_level_sel_high;
        logic winding_a_level_sel_low;
        logic winding_a_output_disable;
        logic winding_b_polarity;
        logic winding_b_level_sel_high;
        logic winding_b_level_sel_low;
        logic winding_b_output_disable;
    } stpq_pins_s;

    localparam stpq_pins_s PINS_RST = 8'h77;

    typedef struct packed {
        logic [1:0] a_level;
        logic       a_polarity;
        logic [1:0] b_level;
        logic       b_polarity;
    } stpq_phase_s;
endpackage : stpq_pkg

/* File: stpq_seq_table.sv */
`timescale 1ns/1ps
module stpq_seq_table (
    input  wire logic [3:0]           pos,
    output stpq_pkg::stpq_phase_s     phase
);
    // position is in quarter steps; half-step state k sits at position 2k
    function automatic logic [1:0] magnitude(input logic [2:0] p);
        unique case (p)
            3'h0, 3'h1, 3'h7: magnitude = stpq_pkg::LVL_FULL;
            3'h2, 3'h6:       magnitude = stpq_pkg::LVL_TWO_THIRD;
            3'h3, 3'h5:       magnitude = stpq_pkg::LVL_ONE_THIRD;
            3'h4:             magnitude = stpq_pkg::LVL_ZERO;
        endcase
    endfunction : magnitude

    logic [2:0] b_pos;

    always_comb begin
        b_pos            = 3'(pos[2:0] + 3'h4);
        phase.a_level    = magnitude(pos[2:0]);
        phase.b_level    = magnitude(b_pos);
        // polarity order of the full cycle; A's off positions 4 and 12 and B's off positions 0 and 8 unused
        phase.a_polarity = (pos >= 4'h5) && (pos <= 4'hB);
        phase.b_polarity = pos[3];
    end
endmodule : stpq_seq_table

/* File: stpq_ctrl.sv */
`timescale 1ns/1ps
module stpq_ctrl (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic [1:0]                hresp,
    output logic [31:0]               hrdata,
    output stpq_pkg::stpq_pins_s      pins
);
    typedef struct packed {
        logic                        dp_write;
        logic [stpq_pkg::ADDR_W-1:0] dp_addr;
        logic [31:0]                 rdata;
        logic [stpq_pkg::CTRL_W-1:0] ctrl;
        logic [stpq_pkg::CNT_W-1:0]  period;
        logic [stpq_pkg::CNT_W-1:0]  remaining;
        logic [stpq_pkg::CNT_W-1:0]  timer;
        logic [3:0]                  pos;
        stpq_pkg::stpq_pins_s        pins;
    } stpq_state_s;

    localparam stpq_state_s STATE_RST = '{
        dp_write:  1'b0,
        dp_addr:   '0,
        rdata:     32'h0000_0000,
        ctrl:      stpq_pkg::CTRL_RST,
        period:    stpq_pkg::PERIOD_RST,
        remaining: 16'h0000,
        timer:     16'h0000,
        pos:       4'h0,
        pins:      stpq_pkg::PINS_RST
    };

    stpq_state_s           state_reg;
    stpq_state_s           state_next;
    stpq_pkg::stpq_phase_s phase;
    logic                  drive_on;
    logic                  quarter;
    logic                  reverse;
    logic                  busy;
    logic                  step_fire;
    logic                  addr_take;
    logic [15:0]           gap;
    logic [31:0]           read_value;

    assign drive_on  = state_reg.ctrl[stpq_pkg::CTRL_DRIVE_BIT];
    assign quarter   = state_reg.ctrl[stpq_pkg::CTRL_QUARTER_BIT];
    assign reverse   = state_reg.ctrl[stpq_pkg::CTRL_REVERSE_BIT];
    assign busy      = state_reg.remaining != 16'h0000;
    assign addr_take = hsel && hready && htrans == stpq_pkg::HTRANS_NONSEQ;
    // short periods are stretched so the driver's guard delays always settle
    assign gap       = (state_reg.period < stpq_pkg::PERIOD_MIN)
                     ? stpq_pkg::PERIOD_MIN : state_reg.period;
    assign step_fire = drive_on && busy && state_reg.timer == 16'h0000;

    assign hreadyout = 1'b1;
    assign hresp     = stpq_pkg::HRESP_OKAY;
    assign hrdata    = state_reg.rdata;
    assign pins      = state_reg.pins;

    stpq_seq_table stpq_seq_table_inst (
        .pos   (state_next.pos),
        .phase (phase)
    );

    always_comb begin
        read_value = 32'h0000_0000;
        unique case (haddr[stpq_pkg::ADDR_W-1:0])
            stpq_pkg::OFS_CTRL:   read_value[2:0]  = state_reg.ctrl;
            stpq_pkg::OFS_STEP:   read_value[15:0] = state_reg.remaining;
            stpq_pkg::OFS_PERIOD: read_value[15:0] = state_reg.period;
            stpq_pkg::OFS_STATUS: begin
                read_value[stpq_pkg::STAT_POS_LSB +: 4] = state_reg.pos;
                read_value[stpq_pkg::STAT_BUSY_BIT]     = busy;
                read_value[stpq_pkg::STAT_PINS_LSB +: 8] = state_reg.pins;
            end
            default:              read_value = 32'h0000_0000;
        endcase
    end

    always_comb begin
        state_next = state_reg;

        // step engine
        if (state_reg.timer != 16'h0000) begin
            state_next.timer = state_reg.timer - 16'h0001;
        end
        if (step_fire) begin
            state_next.remaining = state_reg.remaining - 16'h0001;
            state_next.timer     = gap - 16'h0001;
            if (quarter) begin
                state_next.pos = reverse ? 4'(state_reg.pos - 4'h1)
                                         : 4'(state_reg.pos + 4'h1);
            end else begin
                // half steps land on even positions, wrapping over eight
                state_next.pos = reverse
                    ? {3'(state_reg.pos[3:1] - 3'h1), 1'b0}
                    : {3'(state_reg.pos[3:1] + 3'h1), 1'b0};
            end
        end

        // bus data phase; a count written while stepping adds to the backlog
        state_next.dp_write = addr_take && hwrite;
        state_next.dp_addr  = haddr[stpq_pkg::ADDR_W-1:0];
        if (addr_take && !hwrite) begin
            state_next.rdata = read_value;
        end
        if (state_reg.dp_write) begin
            unique case (state_reg.dp_addr)
                stpq_pkg::OFS_CTRL:   state_next.ctrl   = hwdata[2:0];
                stpq_pkg::OFS_PERIOD: state_next.period = hwdata[15:0];
                stpq_pkg::OFS_STEP:   state_next.remaining =
                    16'(state_next.remaining + hwdata[15:0]);
                default:              ;
            endcase
        end

        // pin drive: the level code alone sets each winding's current;
        // hold current is never reduced; an idle motor keeps its table level
        state_next.pins.winding_a_level_sel_high = phase.a_level[1];
        state_next.pins.winding_a_level_sel_low  = phase.a_level[0];
        state_next.pins.winding_b_level_sel_high = phase.b_level[1];
        state_next.pins.winding_b_level_sel_low  = phase.b_level[0];
        // an off winding keeps its old polarity, so it flips on leaving the off state,
        // when its current starts from zero, or when a reverse half step from an odd position skips that state
        if (phase.a_level != stpq_pkg::LVL_ZERO) begin
            state_next.pins.winding_a_polarity = phase.a_polarity;
        end
        if (phase.b_level != stpq_pkg::LVL_ZERO) begin
            state_next.pins.winding_b_polarity = phase.b_polarity;
        end
        // disables stay low for the whole run; drive off parks both windings
        state_next.pins.winding_a_output_disable =
            !state_next.ctrl[stpq_pkg::CTRL_DRIVE_BIT];
        state_next.pins.winding_b_output_disable =
            !state_next.ctrl[stpq_pkg::CTRL_DRIVE_BIT];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule : stpq_ctrl

/* File: stpq_ctrl_checker.sv */
`timescale 1ns/1ps
module stpq_ctrl_checker (
    input wire logic                 hclk,
    input wire logic                 hresetn,
    input wire logic                 hreadyout,
    input wire logic [1:0]           hresp,
    input wire stpq_pkg::stpq_pins_s pins
);
    logic [1:0] la;
    logic [1:0] lb;
    logic       off;
    logic [5:0] lv_prev;
    logic [6:0] since;
    logic [5:0] lv_now;
    // a step must wait out the driver's longest polarity guard delay
    localparam int GUARD_CYC = 99;
    assign lv_now = {la, lb, pins.winding_a_polarity,
                     pins.winding_b_polarity};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lv_prev <= 6'h3C;
            since   <= 7'h7F;
        end else begin
            lv_prev <= lv_now;
            if (off) begin
                since <= 7'h7F;
            end else if (lv_now != lv_prev) begin
                since <= 7'h00;
            end else if (since != 7'h7F) begin
                since <= 7'(since + 7'h01);
            end
        end
    end
    assign la  = {pins.winding_a_level_sel_high, pins.winding_a_level_sel_low};
    assign lb  = {pins.winding_b_level_sel_high, pins.winding_b_level_sel_low};
    assign off = pins.winding_a_output_disable;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_hold;
        $stable({la, lb})[*8];
    endsequence
    a_bus_ready: assert property (hreadyout == 1'b1) else $error("not ready");
    a_bus_okay: assert property (hresp == 2'h0) else $error("resp not okay");
    a_reset_pins: assert property ($rose(hresetn) |=> pins == 8'h17)
        else $error("pins after reset");
    a_dis_equal:
        assert property (off == pins.winding_b_output_disable)
        else $error("disables differ");
    a_level_pair:
        assert property (!off |->
            {la, lb} inside {4'h3, 4'h2, 4'h5, 4'h8, 4'hC})
        else $error("level pair");
    a_pol_a:
        assert property ($changed(pins.winding_a_polarity) |->
            $past(la) == 2'h3)
        else $error("a polarity while on");
    a_pol_b:
        assert property ($changed(pins.winding_b_polarity) |->
            $past(lb) == 2'h3)
        else $error("b polarity while on");
    a_step_hold:
        assert property ($changed({la, lb}) && !off && !$past(off) |=> s_hold)
        else $error("steps too close");
    a_guard_gap:
        assert property (lv_now != lv_prev && !off && !$past(off) |->
            since >= GUARD_CYC)
        else $error("step inside guard delay");
endmodule : stpq_ctrl_checker

/* File: stpq_drv_model.sv */
`timescale 1ns/1ps
module stpq_drv_model (
    input  wire stpq_pkg::stpq_pins_s pins,
    output logic [2:0]                a_out,
    output logic [2:0]                b_out
);
    // {terminal A high, current in thirds}; all zero when the winding is off
    // off-time regulation and its sensing stay inside the driver and do not
    // show at the logic pins
    function automatic logic [2:0] drv(input logic p, input logic d,
                                       input logic [1:0] l);
        if (d || l == 2'h3)
            return 3'h0;
        return {p, 2'h3 - l};
    endfunction : drv
    assign a_out = drv(pins.winding_a_polarity, pins.winding_a_output_disable,
        {pins.winding_a_level_sel_high, pins.winding_a_level_sel_low});
    assign b_out = drv(pins.winding_b_polarity, pins.winding_b_output_disable,
        {pins.winding_b_level_sel_high, pins.winding_b_level_sel_low});
endmodule : stpq_drv_model

/* File: test_stpq_ctrl.sv */
`timescale 1ns/1ps
module test_stpq_ctrl;
    logic                 hclk;
    logic                 hresetn;
    logic [31:0]          haddr;
    logic [1:0]           htrans;
    logic                 hwrite;
    logic [31:0]          hwdata;
    logic                 hreadyout;
    logic [1:0]           hresp;
    logic [31:0]          hrdata;
    stpq_pkg::stpq_pins_s pins;
    logic [2:0]           a_out;
    logic [2:0]           b_out;
    logic [31:0]          rd;
    int                   err_count;
    int                   comparisons;
    // winding drive per quarter position; B trails A by four positions
    localparam logic [47:0] TAB = 48'h688B_BFFA_829B;

    stpq_ctrl stpq_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pins(pins));
    stpq_drv_model stpq_drv_model_inst (.pins(pins), .a_out(a_out),
        .b_out(b_out));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    // waits for the backlog to drain, then checks position and winding drive
    task automatic steps(input logic [31:0] n, input logic [3:0] p);
        logic [3:0] q;
        q = p - 4'h4;
        ahb(1'b1, stpq_pkg::OFS_STEP, n);
        do ahb(1'b0, stpq_pkg::OFS_STATUS, 32'h0); while (rd[4] !== 1'b0);
        chk(32'(rd[3:0]), 32'(p));
        chk(32'({a_out, b_out}),
            32'({TAB[3*p +: 3], TAB[3*q +: 3]}));
    endtask : steps

    task conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        conclude();
    end

    initial begin
        hresetn = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, stpq_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'(stpq_pkg::CTRL_RST));
        ahb(1'b0, stpq_pkg::OFS_PERIOD, 32'h0);
        chk(rd, 32'(stpq_pkg::PERIOD_RST));
        ahb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        chk(32'(pins), 32'h17);
        $display("reset test done");
        ahb(1'b1, stpq_pkg::OFS_CTRL, 32'h1);
        for (int k = 1; k <= 8; k++)
            steps(32'h1, 4'(2 * k));
        $display("half step test done");
        ahb(1'b1, stpq_pkg::OFS_CTRL, 32'h3);
        for (int k = 1; k <= 16; k++)
            steps(32'h1, 4'(k));
        ahb(1'b1, stpq_pkg::OFS_CTRL, 32'h7);
        steps(32'h2, 4'hE);
        ahb(1'b1, stpq_pkg::OFS_CTRL, 32'h5);
        steps(32'h1, 4'hC);
        steps(32'h1, 4'hA);
        $display("quarter and reverse test done");
        ahb(1'b1, stpq_pkg::OFS_PERIOD, 32'h0000_00C8);
        ahb(1'b0, stpq_pkg::OFS_PERIOD, 32'h0);
        chk(rd, 32'h0000_00C8);
        $display("period test done");
        ahb(1'b1, stpq_pkg::OFS_CTRL, 32'h0);
        ahb(1'b1, stpq_pkg::OFS_STEP, 32'h2);
        ahb(1'b0, stpq_pkg::OFS_STEP, 32'h0);
        chk(rd, 32'h2);
        chk(32'(pins) & 32'h11, 32'h11);
        $display("drive off test done");
        conclude();
    end
endmodule : test_stpq_ctrl

bind stpq_ctrl stpq_ctrl_checker stpq_ctrl_checker_inst (.hclk(hclk),
    .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .pins(pins));
